// file: hdl/mbrm_remap.sv
`timescale 1ns/1ps
`default_nettype none

// Function
// - Each entry multiplies data by its scale
// - Saturate scaled result to signed/unsigned range
// - Inconsistent mapping access answers code 31h
// - Overlapped blocked register answers code 32h
// - Entry valid only if both addresses nonzero
// - Same external, different internal: all invalid
// - Overlapped existing register reachable only via mapping
// - Other half of overlapped double word refused
// - Internal target must be existing single word
// - Mapped read/write goes to internal register
// - Exception echoes slave, function|80h, error code
// - Byte order setting: 00 big, 01 little, 02 special
// - Word high first, except little order
// - Double word 1234, 4321, 3412 by order
// - Same byte order on every communication port
// - At most ten mapping entries
// - Only register data bytes are reordered
// - Remapping only in free mapping mode
module mbrm_remap #(
	parameter int MAP_ENTRIES = mbrm_pkg::MAP_ENTRIES_DEF
) (
	input  wire logic                  clk,
	input  wire logic                  resetn,
	input  wire logic [15:0]           comm_mapping_mode,
	input  wire logic [15:0]           byte_order_setting,
	input  wire mbrm_pkg::mbrm_entry_s map_cfg [MAP_ENTRIES],
	input  wire logic                  req_valid,
	output logic                       req_ready,
	input  wire mbrm_pkg::mbrm_req_s   req,
	output logic                       rsp_valid,
	input  wire logic                  rsp_ready,
	output mbrm_pkg::mbrm_rsp_s        rsp,
	output logic [15:0]                store_addr,
	output logic                       store_wr,
	output logic [31:0]                store_wdata,
	input  wire logic [31:0]           store_rdata,
	input  wire logic [1:0]            store_kind
);
	import mbrm_pkg::*;

	localparam int IDX_W = (MAP_ENTRIES > 1) ? $clog2(MAP_ENTRIES) : 1;

	logic                rst_meta_q;
	logic                rst_n;
	mbrm_state_e         state_q;
	logic [IDX_W-1:0]    idx_q;
	mbrm_entry_s         cfg_q [MAP_ENTRIES];
	logic [15:0]         order_q;
	logic [MAP_ENTRIES-1:0] kind_ok_q;
	logic [MAP_ENTRIES-1:0] entry_ok;
	mbrm_req_s           req_q;
	mbrm_rsp_s           rsp_q;
	logic                rsp_valid_q;
	logic                remap_on;
	logic [15:0]         reg_num;
	logic [15:0]         partner;
	logic                hit;
	logic                hit_bad;
	logic [IDX_W-1:0]    hit_idx;
	logic                partner_hit;
	logic                blocked;
	logic                hit_ok;
	logic [15:0]         eff_scale;
	logic [31:0]         wr_value;
	logic [15:0]         wr_scaled;
	logic [15:0]         rd_scaled;
	mbrm_rsp_s           rsp_d;

	// Scale by a factor held in thousandths, then clamp to the entry's range
	function automatic logic [15:0] scale_sat(input logic [15:0] d, input logic [15:0] s,
		input logic sgn);
		logic signed [33:0] x;
		logic signed [33:0] p;
		x = sgn ? {{18{d[15]}}, d} : {18'h0_0000, d};
		p = (x * $signed({18'h0_0000, s})) / SCALE_DIV;
		if (sgn) begin
			if (p > SAT_S_MAX) p = SAT_S_MAX;
			if (p < SAT_S_MIN) p = SAT_S_MIN;
		end else begin
			if (p > SAT_U_MAX) p = SAT_U_MAX;
			if (p < SAT_U_MIN) p = SAT_U_MIN;
		end
		return p[15:0];
	endfunction : scale_sat

	// Every swap here is its own inverse, so one function serves both directions
	function automatic logic [31:0] order_bytes(input logic [31:0] v, input logic dw,
		input logic [15:0] ord);
		logic [31:0] r;
		r = dw ? v : {16'h0000, v[15:0]};
		if (dw && ord == ORDER_LITTLE)
			r = {v[7:0], v[15:8], v[23:16], v[31:24]};
		else if (dw && ord == ORDER_SPECIAL)
			r = {v[15:0], v[31:16]};
		else if (!dw && ord == ORDER_LITTLE)
			r = {16'h0000, v[7:0], v[15:8]};
		return r;
	endfunction : order_bytes

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_meta_q <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n      <= rst_meta_q;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_LOAD;
			idx_q   <= '0;
		end else begin
			case (state_q)
				ST_LOAD: begin
					state_q <= ST_CHECK;
					idx_q   <= '0;
				end
				ST_CHECK: begin
					if (idx_q == IDX_W'(MAP_ENTRIES - 1))
						state_q <= ST_IDLE;
					idx_q <= idx_q + IDX_W'(1);
				end
				ST_IDLE: begin
					if (req_valid)
						state_q <= ST_LOOKUP;
				end
				ST_LOOKUP: state_q <= ST_RESP;
				ST_RESP: begin
					if (rsp_ready)
						state_q <= ST_IDLE;
				end
				default: state_q <= ST_LOAD;
			endcase
		end
	end

	// Byte order and map entries are copied once after reset; later edits to them wait for the next reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			order_q <= ORDER_BIG;
			for (int i = 0; i < MAP_ENTRIES; i++)
				cfg_q[i] <= '0;
		end else if (state_q == ST_LOAD) begin
			order_q <= byte_order_setting;
			for (int i = 0; i < MAP_ENTRIES; i++)
				cfg_q[i] <= map_cfg[i];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			kind_ok_q <= '0;
		else if (state_q == ST_CHECK)
			kind_ok_q[idx_q] <= (store_kind == KIND_SINGLE);
	end

	always_comb begin
		for (int i = 0; i < MAP_ENTRIES; i++) begin
			entry_ok[i] = cfg_q[i].ext_addr != ADDR_UNUSED && cfg_q[i].int_addr != ADDR_UNUSED
				&& kind_ok_q[i];
			for (int j = 0; j < MAP_ENTRIES; j++) begin
				if (j != i && cfg_q[j].ext_addr == cfg_q[i].ext_addr
					&& cfg_q[j].int_addr != cfg_q[i].int_addr)
					entry_ok[i] = 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			req_q <= '0;
		else if (state_q == ST_IDLE && req_valid)
			req_q <= req;
	end

	assign remap_on = (comm_mapping_mode == MODE_FREE);
	assign reg_num  = req_q.addr + REG_NUM_OFFSET;
	assign partner  = (store_kind == KIND_DW_HIGH) ? reg_num + REG_NUM_OFFSET : reg_num - REG_NUM_OFFSET;

	always_comb begin
		hit         = 1'b0;
		hit_bad     = 1'b0;
		hit_idx     = '0;
		partner_hit = 1'b0;
		for (int i = 0; i < MAP_ENTRIES; i++) begin
			if (remap_on && cfg_q[i].ext_addr != ADDR_UNUSED && cfg_q[i].ext_addr == reg_num) begin
				if (!hit)
					hit_idx = IDX_W'(i);
				hit = 1'b1;
				if (!entry_ok[i])
					hit_bad = 1'b1;
			end
			if (remap_on && cfg_q[i].ext_addr != ADDR_UNUSED && cfg_q[i].ext_addr == partner)
				partner_hit = 1'b1;
		end
	end

	assign blocked   = !hit && partner_hit
		&& (store_kind == KIND_DW_HIGH || store_kind == KIND_DW_LOW);
	assign hit_ok    = hit && !hit_bad && !req_q.dword;
	assign eff_scale = (cfg_q[hit_idx].scale < SCALE_MIN) ? SCALE_MIN : cfg_q[hit_idx].scale;
	assign wr_value  = order_bytes(req_q.wdata, req_q.dword, order_q);
	assign wr_scaled = scale_sat(wr_value[15:0], eff_scale, cfg_q[hit_idx].fmt_signed);
	assign rd_scaled = scale_sat(store_rdata[15:0], eff_scale, cfg_q[hit_idx].fmt_signed);

	always_comb begin
		store_addr  = reg_num;
		store_wr    = 1'b0;
		store_wdata = wr_value;
		if (state_q == ST_CHECK) begin
			store_addr = cfg_q[idx_q].int_addr;
		end else if (state_q == ST_LOOKUP) begin
			if (hit) begin
				store_addr  = cfg_q[hit_idx].int_addr;
				store_wdata = {16'h0000, wr_scaled};
				store_wr    = req_q.write && hit_ok;
			end else begin
				store_wr = req_q.write && !blocked && store_kind != KIND_NONE
					&& (!req_q.dword || store_kind == KIND_DW_HIGH);
			end
		end
	end

	// The port tag is echoed only; ordering is the same whichever port asked
	always_comb begin
		rsp_d       = '0;
		rsp_d.port  = req_q.port;
		rsp_d.slave = req_q.slave;
		rsp_d.func  = req_q.func;
		rsp_d.dword = req_q.dword;
		if (hit && !hit_ok) begin
			rsp_d.exc = 1'b1;
			rsp_d.err = hit_bad ? ERR_MISMATCH : ERR_DUPLICATE;
		end else if (blocked) begin
			rsp_d.exc = 1'b1;
			rsp_d.err = ERR_DUPLICATE;
		end else if (!hit && (store_kind == KIND_NONE
			|| (req_q.dword && store_kind != KIND_DW_HIGH))) begin
			rsp_d.exc = 1'b1;
			rsp_d.err = ERR_BAD_ADDR;
		end
		if (rsp_d.exc)
			rsp_d.func = req_q.func | EXC_FLAG;
		else if (req_q.write)
			rsp_d.rdata = req_q.wdata;
		else
			rsp_d.rdata = order_bytes(hit ? {16'h0000, rd_scaled} : store_rdata,
				req_q.dword, order_q);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rsp_q       <= '0;
			rsp_valid_q <= 1'b0;
		end else if (state_q == ST_LOOKUP) begin
			rsp_q       <= rsp_d;
			rsp_valid_q <= 1'b1;
		end else if (rsp_ready) begin
			rsp_valid_q <= 1'b0;
		end
	end

	assign req_ready = (state_q == ST_IDLE);
	assign rsp_valid = rsp_valid_q;
	assign rsp       = rsp_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_lookup;
		state_q == ST_LOOKUP;
	endsequence
	sequence s_bad_hit;
		s_lookup ##0 (hit && hit_bad);
	endsequence
	sequence s_blocked;
		s_lookup ##0 blocked;
	endsequence
	sequence s_dw_read;
		s_lookup ##0 (!hit && !blocked && req_q.dword && !req_q.write && store_kind == KIND_DW_HIGH);
	endsequence

	a_mismatch_code: assert property (s_bad_hit |=> rsp_valid && rsp.exc && rsp.err == 8'h31)
		else $error("mapping mismatch not answered with 31h");
	a_dup_code: assert property (s_blocked |=> rsp_valid && rsp.exc && rsp.err == 8'h32)
		else $error("blocked register not answered with 32h");
	a_zero_entry: assert property (s_lookup ##0 (hit && cfg_q[hit_idx].int_addr == 16'h0000)
		|=> rsp.err == 8'h31)
		else $error("entry with zero internal address accepted");
	a_mapped_write: assert property (s_lookup ##0 (hit_ok && req_q.write)
		|-> store_wr && store_addr == cfg_q[hit_idx].int_addr)
		else $error("mapped write did not reach internal register");
	a_std_mode: assert property (s_lookup ##0 (comm_mapping_mode == 16'h0000)
		|-> store_addr == req_q.addr + 16'h0001 && !hit)
		else $error("remapping active in standard mode");
	a_exc_func: assert property (s_lookup ##1 (rsp.exc)
		|-> rsp.func == ($past(req_q.func) | 8'h80) && rsp.slave == $past(req_q.slave))
		else $error("exception reply does not echo function with bit 7");
	a_unity_scale: assert property (s_lookup ##0 (hit_ok && !req_q.write && eff_scale == 16'h03E8)
		|-> rd_scaled == store_rdata[15:0])
		else $error("unity scale altered data");
	a_word_little: assert property (s_lookup ##0 (hit_ok && !req_q.write && order_q == 16'h0001)
		|=> rsp.rdata[15:0] == {$past(rd_scaled[7:0]), $past(rd_scaled[15:8])})
		else $error("little order word not low byte first");
	a_init_stall: assert property ((state_q == ST_LOAD) |-> !req_ready [*2] ##1 !req_ready)
		else $error("request accepted before settings latched");
	a_rsp_hold: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp))
		else $error("response dropped before taken");
	a_bad_no_write: assert property (s_bad_hit |-> !store_wr)
		else $error("invalid mapping entry was written");
	a_blocked_no_write: assert property (s_blocked |-> !store_wr)
		else $error("blocked register was written");
	a_dword_hit: assert property (s_lookup ##0 (hit && !hit_bad && req_q.dword)
		|=> rsp_valid && rsp.exc && rsp.err == ERR_DUPLICATE)
		else $error("double word access to mapped number not refused");
	a_dword_big: assert property (s_dw_read ##0 (order_q == ORDER_BIG) |=> rsp.rdata == $past(store_rdata))
		else $error("big order double word not sent as stored");
	a_dword_little: assert property (s_dw_read ##0 (order_q == ORDER_LITTLE)
		|=> rsp.rdata == {$past(store_rdata[7:0]), $past(store_rdata[15:8]),
			$past(store_rdata[23:16]), $past(store_rdata[31:24])})
		else $error("little order double word not reversed");
	a_dword_special: assert property (s_dw_read ##0 (order_q == ORDER_SPECIAL)
		|=> rsp.rdata == {$past(store_rdata[15:0]), $past(store_rdata[31:16])})
		else $error("special order double word halves not swapped");
	a_rsp_port: assert property (s_lookup |=> rsp.port == $past(req_q.port))
		else $error("reply port tag differs from request");
	a_latch_hold: assert property ((state_q != ST_LOAD) |=> $stable(order_q))
		else $error("byte order changed outside settings load");
	a_std_no_block: assert property (s_lookup ##0 (comm_mapping_mode != MODE_FREE) |-> !blocked && !hit)
		else $error("mapping checks active outside free mapping mode");
	a_ext_priority: assert property (s_lookup ##0 hit |-> store_addr == cfg_q[hit_idx].int_addr)
		else $error("mapped number reached the overlapped register");
	a_kind_check: assert property ((state_q == ST_CHECK && store_kind != KIND_SINGLE)
		|=> !kind_ok_q[$past(idx_q)])
		else $error("entry with non single word target kept valid");
	a_write_echo: assert property (s_lookup ##0 (req_q.write && !rsp_d.exc)
		|=> rsp_valid && rsp.rdata == $past(req_q.wdata))
		else $error("write reply does not echo data");

endmodule : mbrm_remap

`default_nettype wire

// file: hdl/mbrm_pkg.sv
package mbrm_pkg;

	localparam int          MAP_ENTRIES_DEF = 10;
	localparam logic [7:0]  ERR_MISMATCH    = 8'h31;
	localparam logic [7:0]  ERR_DUPLICATE   = 8'h32;
	localparam logic [7:0]  ERR_BAD_ADDR    = 8'h02;
	localparam logic [7:0]  EXC_FLAG        = 8'h80;
	localparam logic [15:0] ADDR_UNUSED     = 16'h0000;
	localparam logic [15:0] REG_NUM_OFFSET  = 16'h0001;
	localparam logic [15:0] SCALE_MIN       = 16'h0001;
	localparam logic [15:0] SCALE_UNITY     = 16'h03E8;
	localparam logic signed [33:0] SCALE_DIV = 34'sh0_0000_03E8;
	localparam logic signed [33:0] SAT_S_MAX = 34'sh0_0000_7FFF;
	localparam logic signed [33:0] SAT_S_MIN = -34'sh0_0000_8000;
	localparam logic signed [33:0] SAT_U_MAX = 34'sh0_0000_FFFF;
	localparam logic signed [33:0] SAT_U_MIN = 34'sh0_0000_0000;

	localparam logic [15:0] MODE_STANDARD   = 16'h0000;
	localparam logic [15:0] MODE_FREE       = 16'h0001;
	localparam logic [15:0] ORDER_BIG       = 16'h0000;
	localparam logic [15:0] ORDER_LITTLE    = 16'h0001;
	localparam logic [15:0] ORDER_SPECIAL   = 16'h0002;

	localparam logic [1:0]  KIND_NONE       = 2'h0;
	localparam logic [1:0]  KIND_SINGLE     = 2'h1;
	localparam logic [1:0]  KIND_DW_HIGH    = 2'h2;
	localparam logic [1:0]  KIND_DW_LOW     = 2'h3;

	typedef enum logic [2:0] {ST_LOAD, ST_CHECK, ST_IDLE, ST_LOOKUP, ST_RESP} mbrm_state_e;

	typedef struct packed {
		logic [15:0] ext_addr;
		logic [15:0] int_addr;
		logic        fmt_signed;
		logic [15:0] scale;
	} mbrm_entry_s;

	typedef struct packed {
		logic [1:0]  port;
		logic [7:0]  slave;
		logic [7:0]  func;
		logic [15:0] addr;
		logic        dword;
		logic        write;
		logic [31:0] wdata;
	} mbrm_req_s;

	typedef struct packed {
		logic [1:0]  port;
		logic [7:0]  slave;
		logic [7:0]  func;
		logic        exc;
		logic [7:0]  err;
		logic        dword;
		logic [31:0] rdata;
	} mbrm_rsp_s;

endpackage : mbrm_pkg

// file: sim/mbrm_store_model.sv
`timescale 1ns/1ps
`default_nettype none
module mbrm_store_model (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic [15:0] store_addr,
	input  wire logic        store_wr,
	input  wire logic [31:0] store_wdata,
	output logic [31:0]      store_rdata,
	output logic [1:0]       store_kind
);
	import mbrm_pkg::*;
	logic [15:0] mem [256];
	logic [7:0]  a;
	assign a = store_addr[7:0];
	always_comb begin
		case (store_addr)
			16'h120F, 16'h1210, 16'h1201: store_kind = KIND_SINGLE;
			16'h1103, 16'h1216, 16'h1218: store_kind = KIND_DW_HIGH;
			16'h1104, 16'h1217, 16'h1219: store_kind = KIND_DW_LOW;
			default: store_kind = KIND_NONE;
		endcase
		// Unknown numbers answer an inverted pattern so a stray read never looks valid
		if (store_kind == KIND_NONE)
			store_rdata = ~{store_addr, store_addr};
		else if (store_kind == KIND_DW_HIGH)
			store_rdata = {mem[a], mem[a + 8'h01]};
		else
			store_rdata = {16'h0000, mem[a]};
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < 256; i++)
				mem[i] <= 16'h0000;
			mem[8'h0F] <= 16'h0021;
			mem[8'h10] <= 16'h0064;
			mem[8'h01] <= 16'h0001;
			mem[8'h03] <= 16'h0005;
			mem[8'h04] <= 16'h7E40;
		end else if (store_wr && store_kind == KIND_DW_HIGH) begin
			mem[a] <= store_wdata[31:16];
			mem[a + 8'h01] <= store_wdata[15:0];
		end else if (store_wr) begin
			mem[a] <= store_wdata[15:0];
		end
	end
endmodule : mbrm_store_model
`default_nettype wire

// file: sim/mbrm_remap_tb.sv
`timescale 1ns/1ps
`default_nettype none
module mbrm_remap_tb;
	import mbrm_pkg::*;
	logic        clk = 1'b0;
	logic        resetn = 1'b0;
	logic        req_valid = 1'b0;
	logic        rsp_ready = 1'b0;
	logic        req_ready;
	logic        rsp_valid;
	logic        store_wr;
	logic [15:0] mode = MODE_FREE;
	logic [15:0] order = ORDER_BIG;
	logic [15:0] ph = ORDER_BIG;
	logic [15:0] store_addr;
	logic [31:0] store_wdata;
	logic [31:0] store_rdata;
	logic [1:0]  store_kind;
	mbrm_entry_s cfg [10];
	mbrm_req_s   req = '0;
	mbrm_rsp_s   rsp;
	int          error_cnt = 0;
	int          n_compared = 0;
	logic [15:0] bad [4] = '{16'h6001, 16'h6002, 16'h6004, 16'h6005};

	always #50 clk = ~clk;

	mbrm_remap mbrm_remap_inst (.clk(clk), .resetn(resetn), .comm_mapping_mode(mode),
		.byte_order_setting(order), .map_cfg(cfg), .req_valid(req_valid), .req_ready(req_ready),
		.req(req), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp(rsp), .store_addr(store_addr),
		.store_wr(store_wr), .store_wdata(store_wdata), .store_rdata(store_rdata), .store_kind(store_kind));
	mbrm_store_model mbrm_store_model_inst (.clk(clk), .resetn(resetn), .store_addr(store_addr),
		.store_wr(store_wr), .store_wdata(store_wdata), .store_rdata(store_rdata), .store_kind(store_kind));

	task automatic conclude;
		if (error_cnt == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : conclude

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	function automatic logic [31:0] ww(input logic [15:0] v);
		return (ph == ORDER_LITTLE) ? {16'h0000, v[7:0], v[15:8]} : {16'h0000, v};
	endfunction : ww

	function automatic logic [31:0] dw(input logic [31:0] v);
		if (ph == ORDER_LITTLE)
			return {v[7:0], v[15:8], v[23:16], v[31:24]};
		if (ph == ORDER_SPECIAL)
			return {v[15:0], v[31:16]};
		return v;
	endfunction : dw

	task automatic rst(input logic [15:0] o);
		@(posedge clk);
		resetn <= 1'b0;
		order <= o;
		ph = o;
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		@(negedge clk);
		for (int n = 0; n < 50 && req_ready !== 1'b1; n++)
			@(negedge clk);
	endtask : rst

	// Register number goes in; the address field carries it minus one
	task automatic xfer(input logic [7:0] fn, input logic [15:0] rn, input logic d, input logic [31:0] wd,
		input logic [7:0] er, input logic [31:0] rd);
		@(posedge clk);
		req <= '{port: rn[1:0], slave: 8'h01, func: fn, addr: rn - REG_NUM_OFFSET, dword: d,
			write: fn != 8'h03, wdata: wd};
		req_valid <= 1'b1;
		@(negedge clk);
		for (int n = 0; n < 50 && req_ready !== 1'b1; n++)
			@(negedge clk);
		@(posedge clk);
		req_valid <= 1'b0;
		for (int n = 0; n < 50 && rsp_valid !== 1'b1; n++)
			@(negedge clk);
		chk("valid", 1, rsp_valid);
		chk("port", rn[1:0], rsp.port);
		chk("slave", 8'h01, rsp.slave);
		chk("func", (er != 8'h00) ? (fn | EXC_FLAG) : fn, rsp.func);
		chk("exc", er != 8'h00, rsp.exc);
		chk("err", er, rsp.err);
		chk("rdata", rd, rsp.rdata);
		@(posedge clk);
		rsp_ready <= 1'b1;
		@(posedge clk);
		rsp_ready <= 1'b0;
	endtask : xfer

	initial begin
		#1_000_000;
		error_cnt++;
		conclude;
	end

	initial begin
		cfg <= '{'{16'h4001, 16'h120F, 1'b0, SCALE_UNITY}, '{16'h6001, 16'h0000, 1'b0, SCALE_UNITY},
			'{16'h6002, 16'h1216, 1'b0, SCALE_UNITY}, '{16'h6004, 16'h12FF, 1'b0, SCALE_UNITY},
			'{16'h1217, 16'h1210, 1'b0, SCALE_UNITY}, '{16'h7001, 16'h1201, 1'b0, 16'h07D0},
			'{16'h7002, 16'h1201, 1'b1, 16'h07D0}, '{16'h6005, 16'h120F, 1'b0, SCALE_UNITY},
			'{16'h6005, 16'h1210, 1'b0, SCALE_UNITY}, '{16'h5001, 16'h1210, 1'b0, SCALE_UNITY}};
		for (int p = 0; p < 3; p++) begin
			rst(p[15:0]);
			xfer(8'h03, 16'h4001, 1'b0, 0, 0, ww(16'h0021));
			xfer(8'h03, 16'h1103, 1'b0 | 1'b1, 0, 0, dw(32'h0005_7E40));
			xfer(8'h10, 16'h1103, 1'b1, dw(32'h0001_2345), 0, dw(32'h0001_2345));
			xfer(8'h03, 16'h1103, 1'b1, 0, 0, dw(32'h0001_2345));
		end
		order <= ORDER_BIG;
		xfer(8'h03, 16'h1103, 1'b1, 0, 0, dw(32'h0001_2345));
		rst(ORDER_BIG);
		xfer(8'h06, 16'h4001, 1'b0, 32'h0000_0030, 0, 32'h0000_0030);
		xfer(8'h03, 16'h120F, 1'b0, 0, 0, 32'h0000_0030);
		xfer(8'h03, 16'h7001, 1'b0, 0, 0, 32'h0000_0002);
		xfer(8'h06, 16'h7001, 1'b0, 32'h0000_9000, 0, 32'h0000_9000);
		xfer(8'h03, 16'h1201, 1'b0, 0, 0, 32'h0000_FFFF);
		xfer(8'h03, 16'h7002, 1'b0, 0, 0, 32'h0000_FFFE);
		xfer(8'h06, 16'h7002, 1'b0, 32'h0000_5000, 0, 32'h0000_5000);
		xfer(8'h03, 16'h1201, 1'b0, 0, 0, 32'h0000_7FFF);
		foreach (bad[i])
			xfer(8'h03, bad[i], 1'b0, 0, ERR_MISMATCH, 0);
		xfer(8'h03, 16'h1217, 1'b0, 0, 0, 32'h0000_0064);
		xfer(8'h03, 16'h5001, 1'b0, 0, 0, 32'h0000_0064);
		xfer(8'h03, 16'h1216, 1'b0, 0, ERR_DUPLICATE, 0);
		xfer(8'h10, 16'h1216, 1'b1, 32'h0000_1000, ERR_DUPLICATE, 0);
		xfer(8'h10, 16'h7001, 1'b1, 32'h0000_1000, ERR_DUPLICATE, 0);
		mode <= MODE_STANDARD;
		xfer(8'h03, 16'h4001, 1'b0, 0, ERR_BAD_ADDR, 0);
		xfer(8'h03, 16'h120F, 1'b0, 0, 0, 32'h0000_0030);
		xfer(8'h03, 16'h1217, 1'b0, 0, 0, 32'h0000_0000);
		conclude;
	end
endmodule : mbrm_remap_tb
`default_nettype wire
